// *** hw/ssq_pkg.sv ***
package ssq_pkg;

  // timebase and timing figures in their printed units
  localparam int CLK_MHZ = 100;
  localparam int UNIT_US = 500;
  localparam int STEP_US [4] = '{500, 1000, 2000, 4000};
  localparam int FIRST_US [4] = '{2000, 2500, 4000, 7000};
  localparam int RST_DLY_US = 2000;
  localparam int STANDBY_US = 5000;
  localparam int STANDBY_SLOW_US = 24000;
  localparam int LONG_PRESS_MS = 4000;
  localparam int RST_UNITS = RST_DLY_US / UNIT_US;

  // register port
  localparam int ADDR_W = 5;
  localparam int BUS_W = 16;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ENABLE = 5'h02;
  localparam logic [4:0] REG_SLOT0 = 5'h10;

  // stored word, protected by single-correct double-detect code
  localparam int CFG_W = 8;
  localparam int ECC_P = 4;
  localparam int CODE_W = CFG_W + ECC_P + 1;

  // control word fields
  localparam int CTRL_STEP_LSB = 0;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_ADDR_LSB = 3;
  localparam int CTRL_W = 6;
  localparam logic [3:0] ADDR_FIXED = 4'h1;
  localparam logic [3:0] NO_FEED = 4'hf;

  typedef struct packed {
    logic [2:0] addr_field;
    logic button_edge_mode;
    logic [1:0] seq_step_select;
  } ssq_ctrl_s;

  localparam ssq_ctrl_s DEF_CTRL = '{addr_field: 3'h0, button_edge_mode: 1'b0, seq_step_select: 2'h1};

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_PRE = 5'h02,
    ST_SEQ = 5'h04,
    ST_RST = 5'h08,
    ST_ON = 5'h10
  } ssq_state_e;

  // timebase units per slot
  function automatic int step_units(input logic [1:0] sel);
    return STEP_US[sel] / UNIT_US;
  endfunction : step_units

  // units from turn-on to slot zero
  function automatic int pre_units(input logic [1:0] sel);
    return (FIRST_US[sel] - STEP_US[sel]) / UNIT_US;
  endfunction : pre_units

  // hamming placement, parity at powers of two, overall parity in bit 0
  function automatic logic [CODE_W-1:0] ecc_encode(input logic [CFG_W-1:0] d);
    logic [CODE_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int j = 1; j < CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        c[j] = d[k];
        k++;
      end
    end
    for (int p = 0; p < ECC_P; p++) begin
      for (int j = 1; j < CODE_W; j++) begin
        if (j[p] && j != (1 << p)) c[1 << p] ^= c[j];
      end
    end
    c[0] = ^c;
    return c;
  endfunction : ecc_encode

endpackage : ssq_pkg

// *** hw/ssq_ecc.sv ***
`timescale 1ns/100ps
module ssq_ecc #(
  parameter int DATA_W = 8
) (
  input wire logic [DATA_W+4:0] code,
  output logic [DATA_W-1:0] data,
  output logic err_single,
  output logic err_double
);
  localparam int N = DATA_W + 4;

  if (DATA_W < 1 || DATA_W > 11) begin : g_chk_w
    $error("ssq_ecc DATA_W must be 1 to 11");
  end

  // syndrome, single-bit repair, multi-bit flag
  always_comb begin
    logic [3:0] syn;
    logic ovr;
    logic [N:0] fix;
    int k;
    syn = '0;
    fix = code;
    ovr = ^code;
    k = 0;
    data = '0;
    for (int j = 1; j <= N; j++) begin
      for (int p = 0; p < 4; p++) begin
        if (j[p]) syn[p] ^= code[j];
      end
    end
    err_single = ovr && (int'(syn) <= N);
    err_double = (!ovr && syn != 4'h0) || (ovr && int'(syn) > N);
    if (err_single && syn != 4'h0) fix[syn] = ~fix[syn];
    for (int j = 1; j <= N; j++) begin
      if ((j & (j - 1)) != 0) begin
        data[k] = fix[j];
        k++;
      end
    end
  end

endmodule : ssq_ecc

// *** hw/ssq_sequencer.sv ***
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module ssq_sequencer #(
  parameter int N_OUT = 12,
  parameter int STEP_UNIT_CYC = ssq_pkg::UNIT_US * ssq_pkg::CLK_MHZ,
  parameter int STANDBY_CYC = ssq_pkg::STANDBY_US * ssq_pkg::CLK_MHZ,
  parameter int STANDBY_SLOW_CYC = ssq_pkg::STANDBY_SLOW_US * ssq_pkg::CLK_MHZ,
  parameter int LONG_PRESS_CYC = ssq_pkg::LONG_PRESS_MS * 1000 * ssq_pkg::CLK_MHZ,
  parameter logic [N_OUT*4-1:0] FEED_MAP = {N_OUT{4'hf}},
  parameter logic [N_OUT*5-1:0] DEF_SLOTS = {N_OUT{5'h03}}
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ssq_pkg::ADDR_W-1:0] addr,
  input wire logic [ssq_pkg::BUS_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ssq_pkg::BUS_W-1:0] rd_data,
  input wire logic power_on_input,
  input wire logic coin_cell_input,
  input wire logic fuse_prog_supply,
  output logic [N_OUT-1:0] reg_enable,
  output logic host_reset_out_n,
  output logic standby_supply_out,
  output logic [6:0] slave_addr
);
  localparam int CW = ssq_pkg::CODE_W;
  localparam int NW = N_OUT + 1;
  localparam int UW = $clog2(STEP_UNIT_CYC + 1);
  localparam int SW = $clog2(STANDBY_SLOW_CYC + 1);
  localparam int PW = $clog2(LONG_PRESS_CYC + 1);

  if (N_OUT < 1 || N_OUT > 15) begin : g_chk_n
    $error("N_OUT must be 1 to 15");
  end
  if (STEP_UNIT_CYC < 1 || STANDBY_CYC < 1 || STANDBY_SLOW_CYC < STANDBY_CYC || LONG_PRESS_CYC < 1) begin : g_chk_t
    $error("cycle counts must be positive and ordered");
  end
  for (genvar c = 0; c < N_OUT; c++) begin : g_chk_f
    if (FEED_MAP[c*4+:4] != 4'hf && (FEED_MAP[c*4+:4] >= N_OUT || FEED_MAP[c*4+:4] == c)) begin : g_bad
      $error("FEED_MAP entry names no other output");
    end
  end

  // slot register index for an address, -1 when none
  function automatic int slot_sel(input logic [4:0] a);
    int r;
    r = int'(a) - int'(ssq_pkg::REG_SLOT0);
    if (r < 0 || r >= N_OUT) r = -1;
    return r;
  endfunction : slot_sel

  logic [CW-1:0] cfg_code [NW];
  logic [CW-1:0] next_cfg_code [NW];
  logic [ssq_pkg::CFG_W-1:0] cfg_data [NW];
  logic [NW-1:0] err_single;
  logic [NW-1:0] err_double;
  ssq_pkg::ssq_ctrl_s ctrl_use;
  logic [4:0] slot_use [N_OUT];
  logic [4:0] max_slot;
  logic [7:0] step_u;
  logic [7:0] pre_u;
  ssq_pkg::ssq_state_e state;
  ssq_pkg::ssq_state_e next_state;
  logic [UW-1:0] unit_cnt;
  logic [UW-1:0] next_unit_cnt;
  logic [7:0] units;
  logic [7:0] next_units;
  logic [4:0] cur_slot;
  logic [4:0] next_slot;
  logic [N_OUT-1:0] en;
  logic [N_OUT-1:0] next_en;
  logic [N_OUT-1:0] due;
  logic host_n;
  logic next_host_n;
  logic tick;
  logic btn_prev;
  logic [PW-1:0] press_cnt;
  logic [PW-1:0] next_press_cnt;
  logic turn_on;
  logic turn_off;
  logic cell_ok;
  logic next_cell_ok;
  logic standby;
  logic next_standby;
  logic [SW-1:0] sb_cnt;
  logic [SW-1:0] next_sb_cnt;
  logic [6:0] next_slave_addr;
  logic [ssq_pkg::BUS_W-1:0] next_rd;

  // configuration store: every word kept with its check bits
  always_comb begin
    int sw;
    sw = slot_sel(addr);
    for (int w = 0; w < NW; w++) next_cfg_code[w] = cfg_code[w];
    if (wr_en && addr == ssq_pkg::REG_CTRL) begin
      next_cfg_code[0] = ssq_pkg::ecc_encode({2'h0, wr_data[ssq_pkg::CTRL_W-1:0]});
    end
    if (wr_en && sw >= 0) begin
      next_cfg_code[sw + 1] = ssq_pkg::ecc_encode({3'h0, wr_data[4:0]});
    end
  end

  always_ff @(posedge clk) begin
    for (int w = 0; w < NW; w++) begin
      if (srst) cfg_code[w] <= '0;
      else cfg_code[w] <= next_cfg_code[w];
    end
  end

  // every stored word is read back through the corrector
  for (genvar w = 0; w < NW; w++) begin : g_ecc
    ssq_ecc #(.DATA_W(ssq_pkg::CFG_W)) u_ecc (
      .code(cfg_code[w]),
      .data(cfg_data[w]),
      .err_single(err_single[w]),
      .err_double(err_double[w])
    );
  end

  // live configuration: stored words, or defaults at core level on the fuse pin
  always_comb begin
    ctrl_use = fuse_prog_supply ? ssq_pkg::DEF_CTRL : ssq_pkg::ssq_ctrl_s'(cfg_data[0][ssq_pkg::CTRL_W-1:0]);
    max_slot = 5'h00;
    for (int i = 0; i < N_OUT; i++) begin
      slot_use[i] = fuse_prog_supply ? DEF_SLOTS[i*5+:5] : cfg_data[i+1][4:0];
      if (slot_use[i] > max_slot) max_slot = slot_use[i];
    end
    step_u = 8'(ssq_pkg::step_units(ctrl_use.seq_step_select));
    pre_u = 8'(ssq_pkg::pre_units(ctrl_use.seq_step_select));
  end

  // standby supply delay, longer when the coin cell was not valid first
  always_comb begin
    next_cell_ok = srst ? coin_cell_input : cell_ok;
    next_sb_cnt = standby ? sb_cnt : sb_cnt + 1'b1;
    next_standby = standby;
    if (!standby && sb_cnt == (cell_ok ? SW'(STANDBY_CYC - 1) : SW'(STANDBY_SLOW_CYC - 1))) begin
      next_standby = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    cell_ok <= next_cell_ok;
    if (srst) begin
      sb_cnt <= '0;
      standby <= 1'b0;
    end else begin
      sb_cnt <= next_sb_cnt;
      standby <= next_standby;
    end
  end

  // button: level or edge sense, long press counter
  always_comb begin
    next_press_cnt = '0;
    if (ctrl_use.button_edge_mode && !power_on_input) begin
      next_press_cnt = (press_cnt == PW'(LONG_PRESS_CYC)) ? press_cnt : press_cnt + 1'b1;
    end
    if (ctrl_use.button_edge_mode) begin
      turn_on = state == ssq_pkg::ST_OFF && standby && btn_prev && !power_on_input;
      turn_off = state != ssq_pkg::ST_OFF && !power_on_input && press_cnt >= PW'(LONG_PRESS_CYC - 1);
    end else begin
      turn_on = state == ssq_pkg::ST_OFF && standby && power_on_input;
      turn_off = state != ssq_pkg::ST_OFF && !power_on_input;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      btn_prev <= 1'b0;
      press_cnt <= '0;
    end else begin
      btn_prev <= power_on_input;
      press_cnt <= next_press_cnt;
    end
  end

  // slot sequencer
  always_comb begin
    next_state = state;
    next_unit_cnt = unit_cnt;
    next_units = units;
    next_slot = cur_slot;
    next_en = en;
    next_host_n = host_n;
    tick = unit_cnt == UW'(STEP_UNIT_CYC - 1);
    if (state != ssq_pkg::ST_OFF) next_unit_cnt = tick ? '0 : unit_cnt + 1'b1;
    case (state)
      ssq_pkg::ST_OFF: begin
        if (turn_on) begin
          next_state = ssq_pkg::ST_PRE;
          next_unit_cnt = '0;
          next_units = 8'h00;
          next_slot = 5'h00;
        end
      end
      ssq_pkg::ST_PRE: begin
        if (tick && units == pre_u - 8'h01) begin
          next_units = 8'h00;
          next_state = (max_slot == 5'h00) ? ssq_pkg::ST_RST : ssq_pkg::ST_SEQ;
        end else if (tick) begin
          next_units = units + 8'h01;
        end
      end
      ssq_pkg::ST_SEQ: begin
        if (tick && units == step_u - 8'h01) begin
          next_units = 8'h00;
          next_slot = cur_slot + 5'h01;
          if (next_slot >= max_slot) next_state = ssq_pkg::ST_RST;
        end else if (tick) begin
          next_units = units + 8'h01;
        end
      end
      ssq_pkg::ST_RST: begin
        if (tick && units == 8'(ssq_pkg::RST_UNITS - 1)) begin
          next_state = ssq_pkg::ST_ON;
          next_host_n = 1'b1;
        end else if (tick) begin
          next_units = units + 8'h01;
        end
      end
      ssq_pkg::ST_ON: begin
        next_units = units;
      end
      default: begin
        next_state = ssq_pkg::ST_OFF;
      end
    endcase
    // slots due now; an ldo also waits for its feeding buck
    for (int i = 0; i < N_OUT; i++) begin
      due[i] = slot_use[i] != 5'h00 && slot_use[i] <= next_slot && (state == ssq_pkg::ST_SEQ ||
               state == ssq_pkg::ST_RST || state == ssq_pkg::ST_ON);
    end
    for (int i = 0; i < N_OUT; i++) begin
      if (due[i] && (FEED_MAP[i*4+:4] == ssq_pkg::NO_FEED || en[FEED_MAP[i*4+:4]] || due[FEED_MAP[i*4+:4]])) begin
        next_en[i] = 1'b1;
      end
    end
    if (turn_off) begin
      next_state = ssq_pkg::ST_OFF;
      next_en = '0;
      next_host_n = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ssq_pkg::ST_OFF;
      unit_cnt <= '0;
      units <= 8'h00;
      cur_slot <= 5'h00;
      en <= '0;
      host_n <= 1'b0;
    end else begin
      state <= next_state;
      unit_cnt <= next_unit_cnt;
      units <= next_units;
      cur_slot <= next_slot;
      en <= next_en;
      host_n <= next_host_n;
    end
  end

  // register read data and slave address
  always_comb begin
    int sr;
    sr = slot_sel(addr);
    next_rd = '0;
    next_slave_addr = {ssq_pkg::ADDR_FIXED, ctrl_use.addr_field};
    if (rd_en) begin
      if (addr == ssq_pkg::REG_CTRL) next_rd = 16'(cfg_data[0]);
      else if (addr == ssq_pkg::REG_STATUS) begin
        next_rd = {slave_addr, |err_double, |err_single, host_n, standby, state};
      end else if (addr == ssq_pkg::REG_ENABLE) next_rd = 16'(en);
      else if (sr >= 0) next_rd = 16'(cfg_data[sr + 1]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
      slave_addr <= {ssq_pkg::ADDR_FIXED, 3'h0};
    end else begin
      rd_data <= next_rd;
      slave_addr <= next_slave_addr;
    end
  end

  assign reg_enable = en;
  assign host_reset_out_n = host_n;
  assign standby_supply_out = standby;

  // checking helpers: cycles since turn-on, since reset, of button low
  logic [31:0] on_cyc;
  logic [31:0] rst_cyc;
  logic [31:0] low_cyc;
  always_ff @(posedge clk) begin
    if (srst) begin
      on_cyc <= '0;
      rst_cyc <= '0;
      low_cyc <= '0;
    end else begin
      on_cyc <= turn_on ? 32'h0 : on_cyc + 32'(on_cyc != '1);
      rst_cyc <= rst_cyc + 32'(rst_cyc != '1);
      low_cyc <= power_on_input ? 32'h0 : low_cyc + 32'(low_cyc != '1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  for (genvar i = 0; i < N_OUT; i++) begin : g_chk_out
    slot_off_a: assert property ($rose(en[i]) |-> slot_use[i] != 5'h00)
      else $error("output enabled with slot code zero");
    if (FEED_MAP[i*4+:4] != 4'hf) begin : g_feed
      ldo_gate_a: assert property (en[i] |-> en[FEED_MAP[i*4+:4]])
        else $error("ldo enabled before its feeding buck");
    end
  end

  if (FEED_MAP[3:0] == 4'hf) begin : g_chk_time
    slot_time_a: assert property ($rose(en[0]) |->
      on_cyc == 32'((int'(pre_u) + int'(slot_use[0]) * int'(step_u)) * STEP_UNIT_CYC))
      else $error("slot enable time wrong");
    first_slot_a: assert property (($rose(en[0]) && slot_use[0] == 5'h01) |->
      on_cyc == 32'(ssq_pkg::FIRST_US[ctrl_use.seq_step_select] / ssq_pkg::UNIT_US * STEP_UNIT_CYC))
      else $error("first enable delay wrong");
  end

  if (N_OUT > 1 && FEED_MAP[7:0] == 8'hff) begin : g_chk_same
    same_slot_a: assert property ((slot_use[0] == slot_use[1] && $stable(slot_use[0]) && $stable(slot_use[1]))
      |-> en[0] == en[1])
      else $error("equal slots enabled apart");
  end

  seq_end_a: assert property (state == ssq_pkg::ST_SEQ |-> cur_slot < max_slot)
    else $error("sequencer past last programmed slot");
  rst_release_a: assert property ($rose(host_n) |->
    on_cyc == 32'((int'(pre_u) + int'(max_slot) * int'(step_u) + ssq_pkg::RST_UNITS) * STEP_UNIT_CYC))
    else $error("host reset release time wrong");
  standby_a: assert property ($rose(standby) |->
    rst_cyc == 32'(cell_ok ? STANDBY_CYC : STANDBY_SLOW_CYC))
    else $error("standby supply delay wrong");
  level_on_a: assert property ((!ctrl_use.button_edge_mode && state == ssq_pkg::ST_OFF && standby && power_on_input)
    |=> state == ssq_pkg::ST_PRE)
    else $error("level turn-on missed");
  level_off_a: assert property ((!ctrl_use.button_edge_mode && state != ssq_pkg::ST_OFF && !power_on_input)
    |=> state == ssq_pkg::ST_OFF && en == '0 && !host_n)
    else $error("level turn-off missed");
  edge_on_a: assert property ((ctrl_use.button_edge_mode && state == ssq_pkg::ST_OFF && standby &&
    $fell(power_on_input)) |=> state == ssq_pkg::ST_PRE)
    else $error("edge turn-on missed");
  long_press_a: assert property (($fell(state != ssq_pkg::ST_OFF) && $past(ctrl_use.button_edge_mode)) |->
    low_cyc >= 32'(LONG_PRESS_CYC))
    else $error("edge mode off without long press");
  slave_addr_a: assert property (##1 slave_addr[6:3] == ssq_pkg::ADDR_FIXED &&
    slave_addr[2:0] == $past(ctrl_use.addr_field))
    else $error("slave address out of range");
  ecc_store_a: assert property ((wr_en && addr == ssq_pkg::REG_CTRL) |=>
    cfg_data[0] == {2'h0, $past(wr_data[5:0])} && !err_single[0] && !err_double[0])
    else $error("stored control word not recovered");
  fuse_default_a: assert property ((fuse_prog_supply && $past(fuse_prog_supply)) |->
    slave_addr[2:0] == ssq_pkg::DEF_CTRL.addr_field)
    else $error("default configuration not used");

  power_up_c: cover property ($rose(host_n));
  edge_on_c: cover property (ctrl_use.button_edge_mode && turn_on);
  long_press_c: cover property (ctrl_use.button_edge_mode && turn_off);
  fuse_up_c: cover property ($rose(host_n) && fuse_prog_supply);

endmodule : ssq_sequencer

// *** test/ssq_host_model.sv ***
`timescale 1ns/100ps
module ssq_host_model (
  input wire logic clk,
  input wire logic level_cmd,
  input wire logic press_go,
  input wire logic [31:0] press_len,
  input wire logic host_reset_out_n,
  output logic power_on_input,
  output logic host_up
);
  logic [31:0] press_cnt = 32'h0;

  // counted button press, host side sees reset one cycle late
  always_ff @(posedge clk) begin
    if (press_go) begin
      press_cnt <= press_len;
    end else if (press_cnt != 32'h0) begin
      press_cnt <= press_cnt - 32'h1;
    end
    host_up <= host_reset_out_n;
  end

  // pin follows the level unless a press holds it low
  assign power_on_input = level_cmd && (press_cnt == 32'h0);
endmodule : ssq_host_model

// *** test/startup_slot_sequencer_bench.sv ***
`timescale 1ns/100ps
module startup_slot_sequencer_bench;
  localparam int U = 10;
  localparam int LONG = 100;
  localparam int PRE [4] = '{3, 3, 4, 6};
  logic clk, srst, wr_en, rd_en, level_cmd, press_go, coin, fuse;
  logic [4:0] addr;
  logic [15:0] wr_data, rd_data, rd_val;
  logic [31:0] press_len;
  logic power_on_input, host_reset_out_n, standby_supply_out, host_up;
  logic [11:0] reg_enable;
  logic [6:0] slave_addr;
  int failures, num_checks;
  int cyc = 0;
  int t_en [12];
  int t_rst;

  ssq_sequencer #(.STEP_UNIT_CYC(U), .STANDBY_CYC(20), .STANDBY_SLOW_CYC(50), .LONG_PRESS_CYC(LONG),
    .FEED_MAP({{10{4'hf}}, 4'h0, 4'hf})) i_dut (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .power_on_input(power_on_input),
    .coin_cell_input(coin), .fuse_prog_supply(fuse), .reg_enable(reg_enable),
    .host_reset_out_n(host_reset_out_n), .standby_supply_out(standby_supply_out), .slave_addr(slave_addr));

  ssq_host_model i_host (.clk(clk), .level_cmd(level_cmd), .press_go(press_go), .press_len(press_len),
    .host_reset_out_n(host_reset_out_n), .power_on_input(power_on_input), .host_up(host_up));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask : rd

  function automatic int slot_of(input int i);
    return (i == 1 || i == 2) ? 1 : (i == 0) ? 2 : (i == 3 || i == 4) ? 5 : 0;
  endfunction : slot_of

  // output 1 is fed by output 0, so it waits for slot 2
  function automatic int exp_en(input int i, input int sel);
    int s;
    s = (i == 1) ? 2 : slot_of(i);
    return (s == 0) ? -1 : (PRE[sel] + s * (1 << sel)) * U;
  endfunction : exp_en

  task automatic do_reset(input logic c);
    @(posedge clk);
    srst <= 1'b1;
    coin <= c;
    level_cmd <= 1'b0;
    fuse <= 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1 chk({reg_enable, host_reset_out_n, slave_addr}, {13'h0, 7'h08}, "reset outputs");
    repeat ((c ? 20 : 50) - 2) @(posedge clk);
    #1 chk(standby_supply_out, 1'b0, "standby early");
    repeat (5) @(posedge clk);
    #1 chk(standby_supply_out, 1'b1, "standby late");
  endtask : do_reset

  task automatic write_slots();
    for (int i = 0; i < 12; i++) wr(ssq_pkg::REG_SLOT0 + 5'(i), 16'(slot_of(i)));
  endtask : write_slots

  // E is the edge that returns
  task automatic turn_on(input bit edge_mode);
    @(posedge clk);
    if (edge_mode) begin
      press_len <= 32'd5;
      press_go <= 1'b1;
      @(posedge clk);
      press_go <= 1'b0;
    end else begin
      level_cmd <= 1'b1;
    end
    @(posedge clk);
  endtask : turn_on

  task automatic watch(input int lim);
    t_rst = -1;
    foreach (t_en[i]) t_en[i] = -1;
    for (int n = 1; n <= lim && t_rst < 0; n++) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 12; i++) if (reg_enable[i] === 1'b1 && t_en[i] < 0) t_en[i] = n;
      if (host_reset_out_n === 1'b1) t_rst = n;
    end
  endtask : watch

  task automatic test_regs();
    for (int f = 0; f < 8; f++) begin
      wr(ssq_pkg::REG_CTRL, 16'(f << 3));
      rd(ssq_pkg::REG_CTRL, rd_val);
      chk(rd_val, 32'(f << 3), "ctrl readback");
      chk(slave_addr, {4'h1, 3'(f)}, "slave address");
    end
    rd(5'h1f, rd_val);
    chk(rd_val, 32'h0, "unmapped read");
    rd(ssq_pkg::REG_STATUS, rd_val);
    chk(rd_val[15:7], {7'h0f, 2'b00}, "status ecc flags");
  endtask : test_regs

  task automatic test_level(input int sel);
    wr(ssq_pkg::REG_CTRL, 16'(sel));
    turn_on(1'b0);
    watch(700);
    for (int i = 0; i < 12; i++) chk(t_en[i], exp_en(i, sel), "enable time");
    chk(t_rst, (PRE[sel] + 5 * (1 << sel) + 4) * U, "reset release");
    @(posedge clk);
    #1 chk(host_up, 1'b1, "host sees release");
    @(posedge clk);
    level_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({reg_enable, host_reset_out_n}, 13'h0, "level off");
  endtask : test_level

  task automatic test_edge();
    wr(ssq_pkg::REG_CTRL, 16'h0004);
    @(posedge clk);
    level_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(reg_enable, 12'h0, "rising edge ignored");
    turn_on(1'b1);
    watch(300);
    chk(t_en[2], (3 + 1) * U, "edge turn-on");
    chk(t_rst, (3 + 5 + 4) * U, "edge reset release");
    @(posedge clk);
    press_len <= 32'(LONG + 20);
    press_go <= 1'b1;
    @(posedge clk);
    press_go <= 1'b0;
    repeat (LONG - 10) @(posedge clk);
    #1 chk(host_reset_out_n, 1'b1, "short hold stays on");
    repeat (15) @(posedge clk);
    #1 chk({reg_enable, host_reset_out_n}, 13'h0, "long press off");
  endtask : test_edge

  task automatic test_defaults();
    @(posedge clk);
    fuse <= 1'b1;
    turn_on(1'b0);
    watch(300);
    for (int i = 0; i < 12; i++) chk(t_en[i], 32'd90, "default slot time");
    chk(t_rst, 32'd130, "default reset release");
    rd(ssq_pkg::REG_CTRL, rd_val);
    chk(rd_val, 32'h0, "stored word kept");
  endtask : test_defaults

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    srst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 5'h00;
    wr_data = 16'h0000;
    level_cmd = 1'b0;
    press_go = 1'b0;
    press_len = 32'h0;
    coin = 1'b0;
    fuse = 1'b0;
    failures = 0;
    num_checks = 0;
    do_reset(1'b0);
    do_reset(1'b1);
    test_regs();
    write_slots();
    for (int sel = 0; sel < 4; sel++) test_level(sel);
    do_reset(1'b1);
    write_slots();
    test_edge();
    do_reset(1'b1);
    test_defaults();
    complete_run();
  end
endmodule : startup_slot_sequencer_bench
